// [design/mcs_cfg.svh]
// Function
// [RULE1] Auto-enable: transmitter enabled only while clear-to-send low.
// [RULE2] Auto-enable off: clear-to-send is plain input.
// [RULE3] Both edges of clear-to-send, carrier-detect raise events.
// [RULE4] Auto-enable: receiver enabled only while carrier-detect low.
// [RULE5] Auto-enable off: carrier-detect is plain input.
// [RULE6] Auto-enable off: request-to-send pin inverts control bit.
// [RULE7] Async auto-enable: pin low at once on set.
// [RULE8] Async auto-enable: held low until transmitter empty.
// [RULE9] Frame mode: release after closing flag leaves pin.
// [RULE10] Async receive: sync pin only updates status bit; code also sets the sync interrupt bit on its edges.
// [RULE11] External sync: partner drives sync low two clocks late.
// [RULE12] External sync: assembly starts at preceding receive edge.
// [RULE13] Internal sync: sync pin pulses low on match.
// [RULE14] Sync pin becomes output in sync or frame modes; code drives it in the two sync modes only, and not with the crystal option, never in frame mode.
// [RULE15] All inputs synchronised to the master clock; code synchronises only the clear-to-send, carrier-detect and sync pins.
// [RULE16] Extended register 7 reachable only when enable bit set.
// [RULE17] Inputs pass a two-stage synchroniser first; code does so for the clear-to-send, carrier-detect and sync pins only.
// [RULE18] Reset leaves auto-enable clear, request-to-send high.
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
// Byte addresses of the registers on the register bus.
`define MCS_OFF_CFG3    4'h0
`define MCS_OFF_CFG4    4'h1
`define MCS_OFF_CFG5    4'h2
`define MCS_OFF_EXT7    4'h3
`define MCS_OFF_CFG10   4'h4
`define MCS_OFF_CFG15   4'h5
`define MCS_OFF_STAT0   4'h6
`define MCS_OFF_IRQST   4'h7
`define MCS_OFF_IRQMSK  4'h8
// Field positions.
`define MCS_B_AUTO      5
`define MCS_B_RTS       1
`define MCS_B_EXT7_RTS  2
`define MCS_B_CFG10_B2  2
`define MCS_B_EXT7_EN   0
// Mode field in config register 4: bits 5:4 sync select, bits 3:2 stop.
`define MCS_B_SYNCM_LO  4
`define MCS_B_STOP_LO   2
// Status register 0 bit positions.
`define MCS_S_CD        3
`define MCS_S_SYNC      4
`define MCS_S_CTS       5
// Interrupt bit positions.
`define MCS_I_CTS       0
`define MCS_I_CD        1
`define MCS_I_SYNC      2
// Reset value and sync output pulse length.
`define MCS_RST_BYTE    8'h00
`define MCS_SYNC_PULSE  2
`endif

// [design/mcs_chan.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mcs_cfg.svh"
// One channel of modem-control and sync-pin logic with an Avalon-MM slave.
module mcs_chan
    import mcs_pkg::*;
(
    input  wire logic        mclk,               // Master clock.
    input  wire logic        reset_n,            // Sync reset, active low.
    input  wire logic        ce,                 // Clock enable.
    input  wire logic [3:0]  avs_address,        // Byte address.
    input  wire logic        avs_read,           // Read strobe.
    input  wire logic        avs_write,          // Write strobe.
    input  wire logic [7:0]  avs_writedata,      // Write data.
    output logic [7:0]       avs_readdata,       // Read data.
    output logic             avs_waitrequest,    // Wait request.
    output logic             irq,                // Level interrupt.
    input  wire logic        clear_to_send_in_a, // Clear-to-send, low.
    input  wire logic        carrier_detect_in_a,// Carrier detect, low.
    output logic             request_to_send_out_a, // Request-to-send.
    input  wire logic        sync_pin_a_i,       // Sync pin input level.
    output logic             sync_pin_a_o,       // Sync pin output level.
    output logic             sync_pin_a_oe,      // Sync pin drive enable.
    input  wire logic        rx_clk_rise,        // Receive clock rise pulse.
    input  wire logic        tx_empty,           // Transmitter empty.
    input  wire logic        flag_done,          // Closing flag sent.
    input  wire logic        pattern_match,      // Sync pattern matched.
    input  wire logic        xtal_sel,           // Crystal option in use.
    output logic             tx_enable,          // Transmitter enable.
    output logic             rx_enable,          // Receiver enable.
    output logic             assemble_start      // Begin character assembly.
);
    logic [7:0] cfg3_r, cfg3_nxt;   // Config register 3.
    logic [7:0] cfg4_r, cfg4_nxt;   // Config register 4.
    logic [7:0] cfg5_r, cfg5_nxt;   // Config register 5.
    logic [7:0] ext7_r, ext7_nxt;   // Extended config register 7.
    logic [7:0] cfg10_r, cfg10_nxt; // Config register 10.
    logic [7:0] cfg15_r, cfg15_nxt; // Config register 15.
    logic [2:0] ist_r, ist_nxt;     // Sticky interrupt status.
    logic [2:0] imsk_r, imsk_nxt;   // Interrupt mask.
    logic [7:0] rd_r, rd_nxt;       // Read data register.
    logic       ack_r, ack_nxt;     // Answer phase flag.
    logic [1:0] pcnt_r, pcnt_nxt;   // Sync output pulse counter.
    logic [2:0] rxh_r, rxh_nxt;     // Receive rises of the last 3 cycles.
    logic       cts_q, cts_e;       // Synchronised clear-to-send.
    logic       cd_q, cd_e;         // Synchronised carrier detect.
    logic       syn_q, syn_e;       // Synchronised sync pin.
    logic       auto_en;            // Auto-enable bit.
    logic       ext7_ok;            // Extended register reachable.
    logic       sync_out;           // Sync pin is an output.
    logic       frame_rel;          // Frame-end release active.
    logic       wr, rd;             // Accepted accesses.
    logic [2:0] ev;                 // Events this cycle.
    mcs_mode_e  mode;               // Receive sync mode.

    // Input synchronisers, one per pin.
    mcs_sync2 u_cts (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .d(clear_to_send_in_a), .q(cts_q), .edge_p(cts_e));
    mcs_sync2 u_cd (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .d(carrier_detect_in_a), .q(cd_q), .edge_p(cd_e));
    mcs_sync2 u_syn (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .d(sync_pin_a_i), .q(syn_q), .edge_p(syn_e));

    // Mode decode from the configuration registers.
    always_comb begin
        auto_en   = cfg3_r[`MCS_B_AUTO];
        ext7_ok   = cfg15_r[`MCS_B_EXT7_EN];
        mode      = mcs_mode_e'(cfg4_r[`MCS_B_SYNCM_LO +: 2]);
        // Stop field zero selects the synchronous modes.
        sync_out  = (cfg4_r[`MCS_B_STOP_LO +: 2] == 2'b00)
                    && (mode == MCS_M_SYNC1 || mode == MCS_M_SYNC2)
                    && !xtal_sel;  // [RULE14]
        frame_rel = ext7_r[`MCS_B_EXT7_RTS] && !cfg10_r[`MCS_B_CFG10_B2]
                    && (cfg4_r[`MCS_B_STOP_LO +: 2] == 2'b00)
                    && (mode == MCS_M_EXT);  // [RULE9]
    end

    // Enables: low pins enable only under auto-enable.
    assign tx_enable = auto_en ? !cts_q : 1'b1;  // [RULE1] [RULE2]
    assign rx_enable = auto_en ? !cd_q  : 1'b1;  // [RULE4] [RULE5]

    // Request-to-send output.
    mcs_rts u_rts (.mclk(mclk), .reset_n(reset_n), .ce(ce),
        .auto_en(auto_en), .rts_bit(cfg5_r[`MCS_B_RTS]),
        .frame_rel(frame_rel), .tx_empty(tx_empty),
        .flag_done(flag_done), .rts_n(request_to_send_out_a));

    // Bus acceptance: one wait cycle, answer on the second.
    assign wr              = avs_write && ack_r;
    assign rd              = avs_read && ack_r;
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
    assign avs_readdata    = rd_r;
    assign irq             = |(ist_r & imsk_r);

    // Events; the sync pin counts only when it is an input.
    always_comb begin
        ev = 3'b000;
        ev[`MCS_I_CTS]  = cts_e;                  // [RULE3]
        ev[`MCS_I_CD]   = cd_e;                   // [RULE3]
        ev[`MCS_I_SYNC] = syn_e && !sync_out;     // [RULE10]
    end

    // Register next values and bus handling.
    always_comb begin
        cfg3_nxt  = cfg3_r;
        cfg4_nxt  = cfg4_r;
        cfg5_nxt  = cfg5_r;
        ext7_nxt  = ext7_r;
        cfg10_nxt = cfg10_r;
        cfg15_nxt = cfg15_r;
        imsk_nxt  = imsk_r;
        ist_nxt   = ist_r;
        rd_nxt    = rd_r;
        ack_nxt   = (avs_read | avs_write) & ~ack_r;
        if (wr) begin
            if (avs_address == `MCS_OFF_CFG3) begin
                cfg3_nxt = avs_writedata;
            end else if (avs_address == `MCS_OFF_CFG4) begin
                cfg4_nxt = avs_writedata;
            end else if (avs_address == `MCS_OFF_CFG5) begin
                cfg5_nxt = avs_writedata;
            end else if (avs_address == `MCS_OFF_EXT7 && ext7_ok) begin
                ext7_nxt = avs_writedata;  // [RULE16]
            end else if (avs_address == `MCS_OFF_CFG10) begin
                cfg10_nxt = avs_writedata;
            end else if (avs_address == `MCS_OFF_CFG15) begin
                cfg15_nxt = avs_writedata;
            end else if (avs_address == `MCS_OFF_IRQST) begin
                ist_nxt = ist_r & ~avs_writedata[2:0];
            end else if (avs_address == `MCS_OFF_IRQMSK) begin
                imsk_nxt = avs_writedata[2:0];
            end
        end
        // Set wins over a same-cycle clear.
        ist_nxt = ist_nxt | ev;
        if (avs_read && !ack_r) begin
            rd_nxt = `MCS_RST_BYTE;
            if (avs_address == `MCS_OFF_CFG3) begin
                rd_nxt = cfg3_r;
            end else if (avs_address == `MCS_OFF_CFG4) begin
                rd_nxt = cfg4_r;
            end else if (avs_address == `MCS_OFF_CFG5) begin
                rd_nxt = cfg5_r;
            end else if (avs_address == `MCS_OFF_EXT7 && ext7_ok) begin
                rd_nxt = ext7_r;  // [RULE16]
            end else if (avs_address == `MCS_OFF_CFG10) begin
                rd_nxt = cfg10_r;
            end else if (avs_address == `MCS_OFF_CFG15) begin
                rd_nxt = cfg15_r;
            end else if (avs_address == `MCS_OFF_STAT0) begin
                rd_nxt = 8'h00;
                rd_nxt[`MCS_S_CD]   = !cd_q;
                rd_nxt[`MCS_S_CTS]  = !cts_q;
                rd_nxt[`MCS_S_SYNC] = !syn_q;  // [RULE10]
            end else if (avs_address == `MCS_OFF_IRQST) begin
                rd_nxt = {5'h00, ist_r};
            end else if (avs_address == `MCS_OFF_IRQMSK) begin
                rd_nxt = {5'h00, imsk_r};
            end
        end
    end

    // Register file.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            cfg3_r  <= `MCS_RST_BYTE;  // [RULE18]
            cfg4_r  <= `MCS_RST_BYTE;
            cfg5_r  <= `MCS_RST_BYTE;  // [RULE18]
            ext7_r  <= `MCS_RST_BYTE;
            cfg10_r <= `MCS_RST_BYTE;
            cfg15_r <= `MCS_RST_BYTE;
            ist_r   <= 3'h0;
            imsk_r  <= 3'h0;
            rd_r    <= 8'h00;
            ack_r   <= 1'b0;
        end else if (ce) begin
            cfg3_r  <= cfg3_nxt;
            cfg4_r  <= cfg4_nxt;
            cfg5_r  <= cfg5_nxt;
            ext7_r  <= ext7_nxt;
            cfg10_r <= cfg10_nxt;
            cfg15_r <= cfg15_nxt;
            ist_r   <= ist_nxt;
            imsk_r  <= imsk_nxt;
            rd_r    <= rd_nxt;
            ack_r   <= ack_nxt;
        end
    end

    // Sync output pulse and external-sync assembly start.
    always_comb begin
        pcnt_nxt = pcnt_r;
        if (sync_out && pattern_match) begin
            pcnt_nxt = 2'(`MCS_SYNC_PULSE);  // [RULE13]
        end else if (pcnt_r != 2'd0) begin
            pcnt_nxt = pcnt_r - 2'd1;
        end
        rxh_nxt = {rxh_r[1:0], rx_clk_rise};
    end

    // Pulse counter and receive-edge memory.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            pcnt_r <= 2'd0;
            rxh_r  <= 3'h0;
        end else if (ce) begin
            pcnt_r <= pcnt_nxt;
            rxh_r  <= rxh_nxt;
        end
    end

    assign sync_pin_a_oe = sync_out;                   // [RULE14]
    assign sync_pin_a_o  = !(sync_out && pcnt_r != 2'd0);  // [RULE13]
    // The sync fall arrives two receive clocks after the last bit, per
    // the partner; the synchronised fall lags the pin by one to two
    // clocks, so the receive edge before it lies two or three cycles back.
    assign assemble_start = (mode == MCS_M_EXT) && !sync_out && ce
                            && syn_e && !syn_q
                            && (rxh_r[1] || rxh_r[2]);  // [RULE12] [RULE11]

    tx_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (auto_en && cts_q) |-> !tx_enable)  // [RULE1]
        else $error("transmitter enabled with clear-to-send high");
    rx_gate_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (auto_en && cd_q) |-> !rx_enable)  // [RULE4]
        else $error("receiver enabled with carrier high");
    gp_inputs_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !auto_en |-> (tx_enable && rx_enable))  // [RULE2]
        else $error("enables affected without auto-enable");
    edge_sticky_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && cts_e) |=> ist_r[`MCS_I_CTS])  // [RULE3]
        else $error("clear-to-send edge lost");
    sync_pulse_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && sync_out && pattern_match) |=> !sync_pin_a_o)  // [RULE13]
        else $error("no sync pulse on match");
    sync_dir_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (mode == MCS_M_ASYNC) |-> !sync_pin_a_oe)  // [RULE10]
        else $error("sync pin driven in async mode");
    ext7_lock_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (ce && !ext7_ok) |=> $stable(ext7_r))  // [RULE16]
        else $error("extended register written while locked");
endmodule
`default_nettype wire

// [design/mcs_pkg.sv]
// Types shared by the channel block.
package mcs_pkg;
    // Request-to-send release states.
    typedef enum logic [1:0] {
        MCS_RTS_IDLE = 2'b00,
        MCS_RTS_ON   = 2'b01,
        MCS_RTS_HOLD = 2'b10
    } mcs_rts_e;
    // Receive synchronisation mode decoded from config register 4.
    typedef enum logic [1:0] {
        MCS_M_ASYNC = 2'b00,
        MCS_M_SYNC1 = 2'b01,
        MCS_M_SYNC2 = 2'b10,
        MCS_M_EXT   = 2'b11
    } mcs_mode_e;
endpackage

// [design/mcs_rts.sv]
`timescale 1ns/1ps
`default_nettype none
// Request-to-send output control for one channel.
module mcs_rts
    import mcs_pkg::*;
(
    input  wire logic mclk,      // Master clock.
    input  wire logic reset_n,   // Synchronous reset, active low.
    input  wire logic ce,        // Clock enable.
    input  wire logic auto_en,   // Auto-enable bit.
    input  wire logic rts_bit,   // Request-to-send control bit.
    input  wire logic frame_rel, // Frame-end release option is active.
    input  wire logic tx_empty,  // Transmitter fully empty.
    input  wire logic flag_done, // Closing flag has left the data pin.
    output logic      rts_n      // Pin, active low.
);
    mcs_rts_e st_r, st_nxt;  // Release state.

    // Hold low after clearing until the release event.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            MCS_RTS_IDLE: begin
                if (rts_bit) begin
                    st_nxt = MCS_RTS_ON;
                end
            end
            MCS_RTS_ON: begin
                if (!rts_bit) begin
                    st_nxt = MCS_RTS_HOLD;
                end
            end
            MCS_RTS_HOLD: begin
                if (rts_bit) begin
                    st_nxt = MCS_RTS_ON;
                end else if (frame_rel ? flag_done : tx_empty) begin
                    st_nxt = MCS_RTS_IDLE;  // [RULE8] [RULE9]
                end
            end
            default: st_nxt = MCS_RTS_IDLE;
        endcase
        // Without auto-enable the pin is plain, so no hold is carried over.
        if (!auto_en) begin
            st_nxt = rts_bit ? MCS_RTS_ON : MCS_RTS_IDLE;
        end
    end

    // State register.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_r <= MCS_RTS_IDLE;  // [RULE18]
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    // Pin goes low as soon as the bit is set.
    always_comb begin
        if (!auto_en) begin
            rts_n = ~rts_bit;  // [RULE6]
        end else begin
            // Any state but idle keeps the pin low, so clearing the bit
            // never lets it glitch high before the hold state is reached.
            rts_n = ~(rts_bit | (st_r != MCS_RTS_IDLE));  // [RULE7] [RULE8]
        end
    end

    hold_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (auto_en && st_r == MCS_RTS_HOLD) |-> !rts_n)  // [RULE8]
        else $error("request-to-send released during hold");
    gp_follow_a: assert property (@(posedge mclk) disable iff (!reset_n)
        !auto_en |-> (rts_n == !rts_bit))  // [RULE6]
        else $error("request-to-send does not follow bit");
    set_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (auto_en && rts_bit) |-> !rts_n)  // [RULE7]
        else $error("request-to-send not low when set");
    rts_on_low_a: assert property (@(posedge mclk) disable iff (!reset_n)
        (auto_en && st_r == MCS_RTS_ON) |-> !rts_n)  // [RULE8]
        else $error("request-to-send released after clearing");
endmodule
`default_nettype wire

// [design/mcs_sync2.sv]
`timescale 1ns/1ps
`default_nettype none
// Two-flop synchroniser with edge outputs; the first flop feeds only the second.
module mcs_sync2
    import mcs_pkg::*;
(
    input  wire logic mclk,     // Master clock.
    input  wire logic reset_n,  // Synchronous reset, active low.
    input  wire logic ce,       // Clock enable.
    input  wire logic d,        // Raw pin level.
    output logic      q,        // Synchronised level.
    output logic      edge_p    // One-cycle pulse on either edge.
);
    logic s1_r, s1_nxt;  // First stage.
    logic s2_r, s2_nxt;  // Second stage.
    logic s3_r, s3_nxt;  // Delayed copy for edge detect.

    // Next values of the chain.
    always_comb begin
        s1_nxt = d;
        s2_nxt = s1_r;
        s3_nxt = s2_r;
    end

    // Registers; pins idle high, so reset to one.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
        end else if (ce) begin
            s1_r <= s1_nxt;  // [RULE17] [RULE15]
            s2_r <= s2_nxt;
            s3_r <= s3_nxt;
        end
    end

    assign q      = s2_r;
    assign edge_p = ce & (s2_r ^ s3_r);  // [RULE3]
endmodule
`default_nettype wire

// [tb/mcs_chan_bench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mcs_cfg.svh"
// Compares a design value with its expected value and counts both.
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin \
    err_count++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
// Register-level tests of one modem-control channel.
module mcs_chan_bench
    import mcs_pkg::*;
;
    logic       mclk = 1'b0;        // Master clock, 25 ns period.
    logic       reset_n = 1'b0;     // Sync reset, active low.
    logic [3:0] avs_address = 4'h0; // Bus address.
    logic       avs_read = 1'b0;    // Bus read.
    logic       avs_write = 1'b0;   // Bus write.
    logic [7:0] avs_writedata = 8'h00; // Bus write data.
    logic [7:0] avs_readdata;       // Bus read data.
    logic       avs_waitrequest;    // Bus stall.
    logic       irq;                // Interrupt level.
    logic       cts_lvl = 1'b1;     // Clear-to-send wish, idle high.
    logic       cd_lvl = 1'b1;      // Carrier-detect wish, idle high.
    logic       sync_lvl = 1'b1;    // Sync wish.
    logic       ext_go = 1'b0;      // External sync start.
    logic       cts, cd, rts, sy_i, sy_o, sy_oe, rx_rise; // Pin wires.
    logic       tx_empty = 1'b0;    // Transmitter empty.
    logic       flag_done = 1'b0;   // Closing flag sent.
    logic       pmatch = 1'b0;      // Sync pattern match pulse.
    logic       xtal = 1'b0;        // Crystal option select.
    logic       tx_en, rx_en, asm_go; // Channel enables and start.
    logic [7:0] rd;                 // Last read value.
    int         err_count = 0;      // Mismatches.
    int         num_checks = 0;     // Comparisons.
    int         cyc = 0;            // Cycles run.
    int         n;                  // Scratch counter.

    always #12.5 mclk = ~mclk;

    mcs_chan u_mcs_chan (.mclk(mclk), .reset_n(reset_n), .ce(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq), .clear_to_send_in_a(cts), .carrier_detect_in_a(cd),
        .request_to_send_out_a(rts), .sync_pin_a_i(sy_i),
        .sync_pin_a_o(sy_o), .sync_pin_a_oe(sy_oe), .rx_clk_rise(rx_rise),
        .tx_empty(tx_empty), .flag_done(flag_done), .pattern_match(pmatch),
        .xtal_sel(xtal), .tx_enable(tx_en), .rx_enable(rx_en),
        .assemble_start(asm_go));

    mcs_line_model u_mcs_line_model (.mclk(mclk), .reset_n(reset_n),
        .cts_lvl(cts_lvl), .cd_lvl(cd_lvl), .sync_lvl(sync_lvl),
        .ext_go(ext_go), .sync_pin_a_o(sy_o), .sync_pin_a_oe(sy_oe),
        .clear_to_send_in_a(cts), .carrier_detect_in_a(cd),
        .sync_pin_a_i(sy_i), .rx_clk_rise(rx_rise));

    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // A hung bus or a lost wait ends the run as a failure.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            wrap_up();
        end
    end

    // Bus write held until waitrequest is seen low at an edge.
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    // Bus read; data is taken in the cycle that ends the request.
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge mclk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        `CHK(rd, e)
    endtask

    // Sets the three line levels at a clock edge.
    task automatic pins(input logic c, input logic d, input logic s);
        @(posedge mclk);
        cts_lvl <= c;
        cd_lvl <= d;
        sync_lvl <= s;
    endtask

    // Waits for settled outputs in the middle of a cycle.
    task automatic look(input int k);
        repeat (k) @(negedge mclk);
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        look(1);
        `CHK(rts, 1'b1)
        `CHK(irq, 1'b0)
        for (int a = 0; a < 16; a++) begin
            if (a != `MCS_OFF_STAT0) rd_chk(a[3:0], 8'h00);
        end
        rd_chk(`MCS_OFF_STAT0, 8'h00);
        // Auto-enable off: pins are plain inputs and raise events.
        bus_wr(`MCS_OFF_CFG4, 8'h04);
        pins(1'b0, 1'b0, 1'b1);
        look(6);
        `CHK({tx_en, rx_en}, 2'b11)
        `CHK(irq, 1'b0)
        rd_chk(`MCS_OFF_IRQST, 8'h03);
        bus_wr(`MCS_OFF_IRQMSK, 8'h01);
        look(2);
        `CHK(irq, 1'b1)
        bus_wr(`MCS_OFF_IRQST, 8'h03);
        look(2);
        `CHK(irq, 1'b0)
        pins(1'b1, 1'b1, 1'b1);
        look(6);
        rd_chk(`MCS_OFF_IRQST, 8'h03);
        bus_wr(`MCS_OFF_IRQST, 8'h07);
        pins(1'b0, 1'b0, 1'b1);
        // Plain request-to-send follows the control bit inverted.
        bus_wr(`MCS_OFF_CFG5, 8'h02);
        look(1);
        `CHK(rts, 1'b0)
        bus_wr(`MCS_OFF_CFG5, 8'h00);
        look(1);
        `CHK(rts, 1'b1)
        // Auto-enable on: the two-stage synchroniser sits before the gate.
        bus_wr(`MCS_OFF_CFG3, 8'h20);
        pins(1'b1, 1'b0, 1'b1);
        look(2);
        `CHK(tx_en, 1'b1)
        look(3);
        `CHK({tx_en, rx_en}, 2'b01)
        pins(1'b0, 1'b1, 1'b1);
        look(5);
        `CHK({tx_en, rx_en}, 2'b10)
        pins(1'b0, 1'b0, 1'b1);
        look(5);
        `CHK({tx_en, rx_en}, 2'b11)
        // Async auto mode holds request-to-send until the sender empties.
        bus_wr(`MCS_OFF_CFG5, 8'h02);
        look(1);
        `CHK(rts, 1'b0)
        bus_wr(`MCS_OFF_CFG5, 8'h00);
        look(1);
        `CHK(rts, 1'b0)
        look(4);
        `CHK(rts, 1'b0)
        @(posedge mclk);
        tx_empty <= 1'b1;
        look(3);
        `CHK(rts, 1'b1)
        // Async mode: the sync pin is an input feeding status and the sync interrupt bit.
        `CHK(sy_oe, 1'b0)
        pins(1'b0, 1'b0, 1'b0);
        look(5);
        `CHK({tx_en, rx_en, rts}, 3'b111)
        rd_chk(`MCS_OFF_STAT0, 8'h38);
        pins(1'b0, 1'b0, 1'b1);
        // The extended register is locked until its enable bit is set.
        bus_wr(`MCS_OFF_EXT7, 8'h04);
        rd_chk(`MCS_OFF_EXT7, 8'h00);
        bus_wr(`MCS_OFF_CFG15, 8'h01);
        bus_wr(`MCS_OFF_EXT7, 8'h04);
        rd_chk(`MCS_OFF_EXT7, 8'h04);
        // Frame mode releases request-to-send after the closing flag.
        tx_empty <= 1'b0;
        bus_wr(`MCS_OFF_CFG4, 8'h30);
        bus_wr(`MCS_OFF_CFG5, 8'h02);
        bus_wr(`MCS_OFF_CFG5, 8'h00);
        look(5);
        `CHK(rts, 1'b0)
        @(posedge mclk);
        flag_done <= 1'b1;
        look(3);
        `CHK(rts, 1'b1)
        // External sync: assembly starts once per sync character.
        @(posedge mclk);
        ext_go <= 1'b1;
        n = 0;
        repeat (40) begin
            @(negedge mclk);
            if (asm_go === 1'b1) n++;
        end
        `CHK(n, 1)
        @(posedge mclk);
        ext_go <= 1'b0;
        // Single-character sync drives the pin and pulses it on a match.
        bus_wr(`MCS_OFF_CFG4, 8'h10);
        look(2);
        `CHK(sy_oe, 1'b1)
        @(posedge mclk);
        pmatch <= 1'b1;
        @(posedge mclk);
        pmatch <= 1'b0;
        n = 0;
        repeat (10) begin
            @(negedge mclk);
            if (sy_o === 1'b0) n++;
        end
        `CHK(n, `MCS_SYNC_PULSE)
        // The crystal option takes the sync pin back as an input.
        @(posedge mclk);
        xtal <= 1'b1;
        look(1);
        `CHK(sy_oe, 1'b0)
        wrap_up();
    end
endmodule
`default_nettype wire

// [tb/mcs_line_model.sv]
`timescale 1ns/1ps
`default_nettype none
// Modem and line side of one channel: handshake levels, receive clock and
// an external sync source. The sync wire is resolved as a wired low.
module mcs_line_model
    import mcs_pkg::*;
(
    input  wire logic mclk,                // Master clock.
    input  wire logic reset_n,             // Sync reset, active low.
    input  wire logic cts_lvl,             // Wanted clear-to-send level.
    input  wire logic cd_lvl,              // Wanted carrier-detect level.
    input  wire logic sync_lvl,            // Wanted sync level.
    input  wire logic ext_go,              // Last sync bit has arrived.
    input  wire logic sync_pin_a_o,        // Sync level from the channel.
    input  wire logic sync_pin_a_oe,       // Channel drives the sync pin.
    output logic      clear_to_send_in_a,  // Clear-to-send pin.
    output logic      carrier_detect_in_a, // Carrier-detect pin.
    output logic      sync_pin_a_i,        // Resolved sync wire.
    output logic      rx_clk_rise          // Receive clock rise pulse.
);
    logic [1:0] div_r;  // Receive clock divider, one rise in four cycles.
    logic [1:0] late_r; // Receive clock rises seen since the last bit.

    // The receive clock ticks freely; the late counter stops at two.
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            div_r  <= 2'h0;
            late_r <= 2'h0;
        end else begin
            div_r <= div_r + 2'h1;
            if (!ext_go) begin
                late_r <= 2'h0;
            end else if (rx_clk_rise && late_r != 2'h2) begin
                late_r <= late_r + 2'h1;
            end
        end
    end

    assign rx_clk_rise = (div_r == 2'h3);
    assign clear_to_send_in_a = cts_lvl;
    assign carrier_detect_in_a = cd_lvl;
    // Sync goes low two receive clocks after the last bit.
    assign sync_pin_a_i = (sync_pin_a_oe ? sync_pin_a_o : 1'b1) & sync_lvl
                          & (late_r != 2'h2);
endmodule
`default_nettype wire
